// ==== rtl/tpwm_defines.svh ====
// Offsets, field positions, reset values and counts for the pulse timer
`ifndef TPWM_DEFINES_SVH
`define TPWM_DEFINES_SVH
`define TPWM_OFF_CTRL1   12'h000
`define TPWM_OFF_CTRL2   12'h004
`define TPWM_OFF_STATUS  12'h008
`define TPWM_OFF_CAP1_HI 12'h00C
`define TPWM_OFF_CAP1_LO 12'h010
`define TPWM_OFF_CAP2_HI 12'h014
`define TPWM_OFF_CAP2_LO 12'h018
`define TPWM_OFF_CMP1_HI 12'h01C
`define TPWM_OFF_CMP1_LO 12'h020
`define TPWM_OFF_CMP2_HI 12'h024
`define TPWM_OFF_CMP2_LO 12'h028
`define TPWM_OFF_CNT     12'h02C
`define TPWM_OFF_POWER   12'h030
// Control one
`define TPWM_C1_CAPIE    7
`define TPWM_C1_CMPIE    6
`define TPWM_C1_LVL2     2
`define TPWM_C1_EDGE1    1
`define TPWM_C1_LVL1     0
// Control two
`define TPWM_C2_PIN1E    7
`define TPWM_C2_PIN2E    6
`define TPWM_C2_SPM      5
`define TPWM_C2_PWM      4
`define TPWM_C2_CLK_HI   3
`define TPWM_C2_CLK_LO   2
`define TPWM_C2_EDGE2    1
// Status
`define TPWM_S_CAPF1     7
`define TPWM_S_CMPF1     6
`define TPWM_S_CAPF2     4
`define TPWM_S_CMPF2     3
// Power control
`define TPWM_P_HALT      0
`define TPWM_P_WAKE      1
// Values
`define TPWM_RELOAD      16'hFFFC
`define TPWM_CMP_RESET   16'h8000
`define TPWM_CNT_RESET   16'hFFFC
`define TPWM_CLK_DIV4    2'h0
`define TPWM_CLK_DIV2    2'h1
`define TPWM_CLK_DIV8    2'h2
`define TPWM_CLK_EXT     2'h3
`endif

// ==== rtl/tpwm_pkg.sv ====
// Types shared by the pulse timer
package tpwm_pkg;
  typedef enum logic [1:0] {
    TPWM_MODE_PLAIN,
    TPWM_MODE_SINGLE,
    TPWM_MODE_PWM
  } tpwm_mode_e;
endpackage

// ==== rtl/tpwm_timer.sv ====
// Sixteen-bit timer with single-pulse and PWM modes behind an APB slave
`timescale 1ns/1ps
`include "tpwm_defines.svh"
module tpwm_timer
  import tpwm_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        capture_input_one,
  input  wire logic        capture_input_two,
  output logic             compare_output_one,
  output logic             compare_output_one_en,
  output logic             compare_output_two,
  output logic             compare_output_two_en,
  output logic             timer_irq,
  output logic             wake_request
);
  if (CNT_W != 16) begin : g_cnt_w_check
    $error("tpwm_timer supports only a 16-bit counter");
  end

  // ==========================================================
  // Bus decode
  // ==========================================================
  logic [7:0]  timer_control_one_q, timer_control_two_q;
  logic [15:0] counter_q, counter_d;
  logic [15:0] compare_one_value_q, compare_two_value_q;
  logic [15:0] shadow_one_q, shadow_two_q;
  logic [15:0] capture_one_value_q, capture_two_value_q;
  logic        capture_flag_one_q, capture_flag_two_q;
  logic        compare_flag_one_q, compare_flag_two_q;
  logic        arm1_q, arm2_q, lock1_q, lock2_q, caplk1_q, caplk2_q;
  logic        cmp_inh1_q, cmp_inh2_q;
  logic        halt_q, pend1_q, pend2_q;
  logic        in1_q, in2_q;
  logic [2:0]  presc_q;
  logic        pin1_q;

  wire access = psel & penable;
  wire wr     = access & pwrite & pstrb[0];
  wire rd     = access & ~pwrite;
  wire hit_c1  = paddr == `TPWM_OFF_CTRL1;
  wire hit_c2  = paddr == `TPWM_OFF_CTRL2;
  wire hit_st  = paddr == `TPWM_OFF_STATUS;
  wire hit_i1h = paddr == `TPWM_OFF_CAP1_HI;
  wire hit_i1l = paddr == `TPWM_OFF_CAP1_LO;
  wire hit_i2h = paddr == `TPWM_OFF_CAP2_HI;
  wire hit_i2l = paddr == `TPWM_OFF_CAP2_LO;
  wire hit_o1h = paddr == `TPWM_OFF_CMP1_HI;
  wire hit_o1l = paddr == `TPWM_OFF_CMP1_LO;
  wire hit_o2h = paddr == `TPWM_OFF_CMP2_HI;
  wire hit_o2l = paddr == `TPWM_OFF_CMP2_LO;
  wire hit_cnt = paddr == `TPWM_OFF_CNT;
  wire hit_pwr = paddr == `TPWM_OFF_POWER;
  wire mapped  = hit_c1 | hit_c2 | hit_st | hit_i1h | hit_i1l | hit_i2h |
                 hit_i2l | hit_o1h | hit_o1l | hit_o2h | hit_o2l |
                 hit_cnt | hit_pwr;

  // ==========================================================
  // Mode and prescaler
  // ==========================================================
  wire [1:0] clk_sel = timer_control_two_q[`TPWM_C2_CLK_HI:`TPWM_C2_CLK_LO];
  wire pwm_bit = timer_control_two_q[`TPWM_C2_PWM];
  wire spm_bit = timer_control_two_q[`TPWM_C2_SPM];
  tpwm_mode_e mode;
  assign mode = pwm_bit ? TPWM_MODE_PWM :
                spm_bit ? TPWM_MODE_SINGLE : TPWM_MODE_PLAIN;
  wire lvl1  = timer_control_one_q[`TPWM_C1_LVL1];
  wire lvl2  = timer_control_one_q[`TPWM_C1_LVL2];
  wire capie = timer_control_one_q[`TPWM_C1_CAPIE];
  wire cmpie = timer_control_one_q[`TPWM_C1_CMPIE];

  function automatic logic [2:0] div_mask(input logic [1:0] sel);
    case (sel)
      `TPWM_CLK_DIV2: div_mask = 3'h1;
      `TPWM_CLK_DIV8: div_mask = 3'h7;
      default:        div_mask = 3'h3;
    endcase
  endfunction

  // No external clock pin here: that selection freezes the count
  wire tick = ~halt_q & (clk_sel != `TPWM_CLK_EXT) &
              ((presc_q & div_mask(clk_sel)) == div_mask(clk_sel));

  function automatic logic edge_hit(input logic prev, input logic now,
                                    input logic rise);
    edge_hit = rise ? (~prev & now) : (prev & ~now);
  endfunction

  wire e1 = edge_hit(in1_q, capture_input_one,
                     timer_control_one_q[`TPWM_C1_EDGE1]);
  wire e2 = edge_hit(in2_q, capture_input_two,
                     timer_control_two_q[`TPWM_C2_EDGE2]);
  wire ev1 = e1 & ~caplk1_q;
  wire ev2 = e2 & ~caplk2_q;

  // ==========================================================
  // Compare and capture events
  // ==========================================================
  wire use_shadow = mode == TPWM_MODE_PWM;
  wire [15:0] ref1 = use_shadow ? shadow_one_q : compare_one_value_q;
  wire [15:0] ref2 = use_shadow ? shadow_two_q : compare_two_value_q;
  // PWM compares are never inhibited by a half-written value
  wire m1 = tick & (counter_q == ref1) &
            (use_shadow | ~cmp_inh1_q);
  wire m2 = tick & (counter_q == ref2) & (use_shadow | ~cmp_inh2_q);
  wire trig = ev1 & ~halt_q & (mode == TPWM_MODE_SINGLE);
  wire pwm_end = m2 & (mode == TPWM_MODE_PWM);
  wire cap1 = ~halt_q & ((ev1 & mode == TPWM_MODE_PLAIN) | trig |
              (pend1_q & ~halt_q));
  wire cap2 = ~halt_q & (ev2 | pend2_q);
  wire wake = halt_q & wr & hit_pwr & pwdata[`TPWM_P_WAKE];

  always_comb begin
    counter_d = counter_q;
    if (trig | pwm_end) begin
      counter_d = `TPWM_RELOAD;
    end else if (tick) begin
      counter_d = counter_q + 16'h0001;
    end
    if (wr & hit_cnt) begin
      counter_d = `TPWM_CNT_RESET;
    end
  end

  // Clearing: status read while set arms, low-byte access clears
  wire st_rd = rd & hit_st;
  wire clr_i1 = arm1_q & access & hit_i1l;
  wire clr_i2 = arm2_q & access & hit_i2l;
  wire clr_o1 = access & hit_o1l;
  wire clr_o2 = access & hit_o2l;
  wire set_i1 = cap1 | pwm_end;
  wire set_o1 = m1 & (mode == TPWM_MODE_PLAIN);
  wire set_o2 = m2 & (mode != TPWM_MODE_PWM);

  wire [7:0] status = {capture_flag_one_q, compare_flag_one_q, 1'b0,
                       capture_flag_two_q, compare_flag_two_q, 3'h0};

  wire [15:0] rd_cap1 = capture_one_value_q;
  wire [15:0] rd_cap2 = capture_two_value_q;
  wire [31:0] rdata_d =
    hit_c1  ? {24'h0, timer_control_one_q} :
    hit_c2  ? {24'h0, timer_control_two_q} :
    hit_st  ? {24'h0, status} :
    hit_i1h ? {24'h0, rd_cap1[15:8]} :
    hit_i1l ? {24'h0, rd_cap1[7:0]} :
    hit_i2h ? {24'h0, rd_cap2[15:8]} :
    hit_i2l ? {24'h0, rd_cap2[7:0]} :
    hit_o1h ? {24'h0, compare_one_value_q[15:8]} :
    hit_o1l ? {24'h0, compare_one_value_q[7:0]} :
    hit_o2h ? {24'h0, compare_two_value_q[15:8]} :
    hit_o2l ? {24'h0, compare_two_value_q[7:0]} :
    hit_cnt ? {16'h0, counter_q} :
    hit_pwr ? {31'h0, halt_q} : 32'h0;

  // Pin level: single-pulse and PWM drive the pin for both levels
  logic pin1_d;
  always_comb begin
    pin1_d = pin1_q;
    if (mode == TPWM_MODE_SINGLE) begin
      if (trig) begin
        pin1_d = lvl2;
      end else if (m1) begin
        pin1_d = lvl1;
      end
    end else if (mode == TPWM_MODE_PWM) begin
      if (m2) begin
        pin1_d = lvl2;
      end else if (m1) begin
        pin1_d = lvl1;
      end
    end else if (m1) begin
      pin1_d = lvl1;
    end
  end

  // ==========================================================
  // Registers
  // ==========================================================
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      timer_control_one_q <= 8'h00;
      timer_control_two_q <= 8'h00;
      counter_q <= `TPWM_CNT_RESET;
      presc_q <= 3'h0;
      in1_q <= 1'b0;
      in2_q <= 1'b0;
      halt_q <= 1'b0;
      pend1_q <= 1'b0;
      pend2_q <= 1'b0;
    end else begin
      if (wr & hit_c1) begin
        timer_control_one_q <= pwdata[7:0];
      end
      if (wr & hit_c2) begin
        timer_control_two_q <= pwdata[7:0];
      end
      counter_q <= counter_d;
      presc_q <= halt_q ? presc_q : presc_q + 3'h1;
      in1_q <= capture_input_one;
      in2_q <= capture_input_two;
      if (wr & hit_pwr & pwdata[`TPWM_P_HALT]) begin
        halt_q <= 1'b1;
      end else if (wake) begin
        halt_q <= 1'b0;
      end
      // Capture edges seen in halt (input one in plain mode only) arm detection until wake
      pend1_q <= halt_q ? (pend1_q | (ev1 & mode == TPWM_MODE_PLAIN))
                        : 1'b0;
      pend2_q <= halt_q ? (pend2_q | ev2) : 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      compare_one_value_q <= `TPWM_CMP_RESET;
      compare_two_value_q <= `TPWM_CMP_RESET;
      shadow_one_q <= `TPWM_CMP_RESET;
      shadow_two_q <= `TPWM_CMP_RESET;
      lock1_q <= 1'b0;
      lock2_q <= 1'b0;
      cmp_inh1_q <= 1'b0;
      cmp_inh2_q <= 1'b0;
    end else begin
      if (wr & hit_o1h) begin
        compare_one_value_q[15:8] <= pwdata[7:0];
      end
      if (wr & hit_o1l) begin
        compare_one_value_q[7:0] <= pwdata[7:0];
      end
      if (wr & hit_o2h) begin
        compare_two_value_q[15:8] <= pwdata[7:0];
      end
      if (wr & hit_o2l) begin
        compare_two_value_q[7:0] <= pwdata[7:0];
      end
      lock1_q <= (wr & hit_o1h) | (lock1_q & ~(wr & hit_o1l));
      lock2_q <= (wr & hit_o2h) | (lock2_q & ~(wr & hit_o2l));
      cmp_inh1_q <= (wr & hit_o1h) | (cmp_inh1_q & ~(wr & hit_o1l));
      cmp_inh2_q <= (wr & hit_o2h) | (cmp_inh2_q & ~(wr & hit_o2l));
      if ((pwm_end | mode != TPWM_MODE_PWM) & ~lock1_q) begin
        shadow_one_q <= compare_one_value_q;
      end
      if ((pwm_end | mode != TPWM_MODE_PWM) & ~lock2_q) begin
        shadow_two_q <= compare_two_value_q;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      capture_one_value_q <= 16'h0000;
      capture_two_value_q <= 16'h0000;
      capture_flag_one_q <= 1'b0;
      capture_flag_two_q <= 1'b0;
      compare_flag_one_q <= 1'b0;
      compare_flag_two_q <= 1'b0;
      arm1_q <= 1'b0;
      arm2_q <= 1'b0;
      caplk1_q <= 1'b0;
      caplk2_q <= 1'b0;
    end else begin
      if (cap1) begin
        capture_one_value_q <= counter_q;
      end
      if (cap2) begin
        capture_two_value_q <= counter_q;
      end
      // Set wins over a clear in the same cycle
      capture_flag_one_q <= set_i1 | (capture_flag_one_q & ~clr_i1);
      capture_flag_two_q <= cap2 | (capture_flag_two_q & ~clr_i2);
      compare_flag_one_q <= set_o1 |
                            (compare_flag_one_q & ~(arm1_q & clr_o1));
      compare_flag_two_q <= set_o2 |
                            (compare_flag_two_q & ~(arm2_q & clr_o2));
      arm1_q <= (st_rd & (capture_flag_one_q | compare_flag_one_q)) |
                (arm1_q & ~clr_i1 & ~clr_o1);
      arm2_q <= (st_rd & (capture_flag_two_q | compare_flag_two_q)) |
                (arm2_q & ~clr_i2 & ~clr_o2);
      // High-byte read freezes capture until low byte read
      caplk1_q <= (rd & hit_i1h) | (caplk1_q & ~(rd & hit_i1l));
      caplk2_q <= (rd & hit_i2h) | (caplk2_q & ~(rd & hit_i2l));
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  wire irq_d = (capie & (capture_flag_one_q | capture_flag_two_q)) |
               (cmpie & (compare_flag_one_q | compare_flag_two_q));
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      pin1_q <= 1'b0;
      compare_output_one <= 1'b0;
      compare_output_one_en <= 1'b0;
      compare_output_two <= 1'b0;
      compare_output_two_en <= 1'b0;
      timer_irq <= 1'b0;
      wake_request <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      prdata <= (psel & ~penable & ~pwrite) ? rdata_d : prdata;
      pslverr <= psel & ~penable & ~mapped;
      pin1_q <= pin1_d;
      compare_output_one <= pin1_d;
      compare_output_one_en <= timer_control_two_q[`TPWM_C2_PIN1E];
      if (set_o2 & mode == TPWM_MODE_PLAIN) begin
        compare_output_two <= lvl2;
      end
      compare_output_two_en <= timer_control_two_q[`TPWM_C2_PIN2E] &
                               (mode == TPWM_MODE_PLAIN);
      timer_irq <= irq_d;
      wake_request <= irq_d;
    end
  end
endmodule

// ==== tb/tpwm_timer_asserts.sv ====
// Checker for bus timing, pin enables and interrupt gating of the timer
`timescale 1ns/1ps
`include "tpwm_defines.svh"
module tpwm_timer_asserts #(
  parameter int CNT_W = 16
) (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        compare_output_one,
  input wire logic        compare_output_one_en,
  input wire logic        compare_output_two_en,
  input wire logic        timer_irq,
  input wire logic        wake_request
);
  // ==============================
  // Copies of mode and enable bits
  logic       wr_ok;
  logic [1:0] mode_q;
  logic [1:0] ie_q;
  assign wr_ok = psel && penable && pready && pwrite && pstrb[0];
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= 2'h0;
      ie_q   <= 2'h0;
    end else if (wr_ok && paddr == `TPWM_OFF_CTRL2) begin
      mode_q <= pwdata[5:4];
    end else if (wr_ok && paddr == `TPWM_OFF_CTRL1) begin
      ie_q <= pwdata[7:6];
    end
  end
  // ==============================
  // Properties
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  property p_ready;
    psel && !penable |=> pready ##1 !pready;
  endproperty
  property p_err;
    pready && paddr > `TPWM_OFF_POWER |-> pslverr;
  endproperty
  property p_ok;
    pready && paddr <= `TPWM_OFF_POWER && paddr[1:0] == 2'h0
      |-> !pslverr && prdata[31:16] == 16'h0;
  endproperty
  property p_rst;
    $rose(rst_n) |-> !compare_output_one && !timer_irq;
  endproperty
  property p_pin1e;
    wr_ok && paddr == `TPWM_OFF_CTRL2
      |=> ##1 compare_output_one_en == $past(pwdata[7], 2);
  endproperty
  property p_pin2e;
    mode_q != 2'h0 && $past(mode_q) != 2'h0 |-> !compare_output_two_en;
  endproperty
  property p_irq;
    timer_irq |-> ie_q != 2'h0 || $past(ie_q) != 2'h0;
  endproperty
  property p_wake;
    $rose(timer_irq) |-> ##[0:1] wake_request;
  endproperty
  property p_pwm_flags;
    mode_q[0] && pready && !pwrite && paddr == `TPWM_OFF_STATUS
      |-> !prdata[6] && !prdata[3];
  endproperty
  a_ready:     assert property (p_ready) else $error("pready timing");
  a_err:       assert property (p_err) else $error("no slave error");
  a_ok:        assert property (p_ok) else $error("bad mapped answer");
  a_rst:       assert property (p_rst) else $error("pin after reset");
  a_pin1e:     assert property (p_pin1e) else $error("pin one enable");
  a_pin2e:     assert property (p_pin2e) else $error("pin two enable");
  a_irq:       assert property (p_irq) else $error("irq not enabled");
  a_wake:      assert property (p_wake) else $error("no wake");
  a_pwm_flags: assert property (p_pwm_flags) else $error("pwm flag");
  c_pwm: cover property (mode_q[0] && pready);
  c_err: cover property (pslverr);
  c_irq: cover property ($rose(timer_irq));
endmodule

bind tpwm_timer tpwm_timer_asserts #(.CNT_W(CNT_W)) tpwm_timer_asserts_i (
  .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .compare_output_one(compare_output_one),
  .compare_output_one_en(compare_output_one_en),
  .compare_output_two_en(compare_output_two_en),
  .timer_irq(timer_irq), .wake_request(wake_request)
);

// ==== tb/tpwm_pin_model.sv ====
// Event source on the capture inputs and watcher of compare pin one
`timescale 1ns/1ps
module tpwm_pin_model (
  input  wire logic mclk,
  input  wire logic pin,
  input  wire logic pin_en,
  output logic      cap_one,
  output logic      cap_two
);
  logic seen;
  // Undriven pin reads as the board pull-down
  assign seen = pin_en ? pin : 1'b0;
  initial begin
    cap_one = 1'b0;
    cap_two = 1'b0;
  end
  // ==============================
  // Edge source, changed just after a rising edge
  task automatic drive(input logic ch, input logic lvl);
    @(posedge mclk);
    if (ch) begin
      cap_two <= lvl;
    end else begin
      cap_one <= lvl;
    end
  endtask
  // ==============================
  // Pin timing in cycles, sampled on the quiet edge
  task automatic wait_lvl(input logic v, output int cnt);
    cnt = 0;
    while (seen !== v && cnt < 5000) begin
      @(negedge mclk);
      cnt++;
    end
  endtask
  task automatic pulse(output int hi);
    int n;
    wait_lvl(1'b1, n);
    wait_lvl(1'b0, hi);
  endtask
  task automatic meas(output int hi, output int per);
    int n;
    int lo;
    wait_lvl(1'b0, n);
    wait_lvl(1'b1, n);
    wait_lvl(1'b0, hi);
    wait_lvl(1'b1, lo);
    per = hi + lo;
  endtask
endmodule

// ==== tb/tb.sv ====
// Self-checking bench for the pulse timer
`timescale 1ns/1ps
`include "tpwm_defines.svh"
module tb;
  logic        mclk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        cap_one;
  logic        cap_two;
  logic        pin;
  logic        pin_en;
  logic        pin2_en;
  logic        pin2;
  logic        irq;
  logic        wake;
  logic [31:0] rd_v;
  logic [31:0] cnt_v;
  logic        er_v;
  int          err_count;
  int          n_checks;
  int          hi;
  int          per;

  tpwm_timer tpwm_timer_i (
    .mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capture_input_one(cap_one), .capture_input_two(cap_two),
    .compare_output_one(pin), .compare_output_one_en(pin_en),
    .compare_output_two(pin2), .compare_output_two_en(pin2_en),
    .timer_irq(irq), .wake_request(wake)
  );
  tpwm_pin_model tpwm_pin_model_i (
    .mclk(mclk), .pin(pin), .pin_en(pin_en),
    .cap_one(cap_one), .cap_two(cap_two)
  );

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // ==============================
  // Bus and compare helpers
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [7:0] d, input logic [3:0] s);
    @(posedge mclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    pstrb   <= s;
    @(posedge mclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd_v = prdata;
    er_v = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d, 4'hF);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    apb(1'b0, a, 8'h00, 4'h0);
    chk(rd_v & m, e);
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Generous bound, the sequence needs a few thousand cycles
  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    test_done();
  end

  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
    err_count = 0;
    n_checks = 0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    // ==============================
    // Reset state and refused accesses
    chk({31'h0, pin}, 32'h0);
    rdc(`TPWM_OFF_CTRL2, 32'hFF, 32'h0);
    rdc(`TPWM_OFF_CMP1_HI, 32'hFF, 32'h80);
    apb(1'b1, `TPWM_OFF_CTRL1, 8'hFF, 4'h0);
    rdc(`TPWM_OFF_CTRL1, 32'hFF, 32'h0);
    rdc(12'h040, 32'hFFFFFFFF, 32'h0);
    chk({31'h0, er_v}, 32'h1);
    // ==============================
    // Plain compare two drives its own pin
    wr(`TPWM_OFF_CNT, 8'h00);
    wr(`TPWM_OFF_CTRL1, 8'h04);
    wr(`TPWM_OFF_CMP2_HI, 8'h00);
    wr(`TPWM_OFF_CMP2_LO, 8'h08);
    wr(`TPWM_OFF_CTRL2, 8'h40);
    chk({31'h0, pin2}, 32'h0);
    repeat (50) @(posedge mclk);
    chk({30'h0, pin2, pin2_en}, 32'h3);
    // ==============================
    // Single pulse, falling trigger
    // Restart the count so compare one is not passed in plain mode
    wr(`TPWM_OFF_CNT, 8'h00);
    wr(`TPWM_OFF_CMP1_HI, 8'h00);
    wr(`TPWM_OFF_CMP1_LO, 8'h10);
    wr(`TPWM_OFF_CMP2_HI, 8'h00);
    wr(`TPWM_OFF_CMP2_LO, 8'h30);
    wr(`TPWM_OFF_CTRL1, 8'h84);
    wr(`TPWM_OFF_CTRL2, 8'hE6);
    // Pin enables follow the control write one cycle later
    repeat (2) @(posedge mclk);
    chk({30'h0, pin2_en, pin_en}, 32'h1);
    tpwm_pin_model_i.drive(1'b0, 1'b1);
    repeat (4) @(posedge mclk);
    rdc(`TPWM_OFF_STATUS, 32'h80, 32'h0);
    tpwm_pin_model_i.drive(1'b0, 1'b0);
    tpwm_pin_model_i.pulse(hi);
    chk({31'h0, hi >= 40 && hi <= 44}, 32'h1);
    tpwm_pin_model_i.drive(1'b1, 1'b1);
    repeat (100) @(posedge mclk);
    rdc(`TPWM_OFF_STATUS, 32'hD8, 32'h98);
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, `TPWM_OFF_CAP1_LO, 8'h00, 4'h0);
    rdc(`TPWM_OFF_STATUS, 32'h80, 32'h0);
    // ==============================
    // PWM at each prescale, both mode bits set
    wr(`TPWM_OFF_CTRL1, 8'h41);
    wr(`TPWM_OFF_CMP2_LO, 8'h20);
    for (int i = 0; i < 3; i++) begin
      wr(`TPWM_OFF_CTRL2, {4'hB, i == 2, i == 0, 2'h0});
      // Count is past compare two after the pulse: avoid a full wrap
      wr(`TPWM_OFF_CNT, 8'h00);
      tpwm_pin_model_i.meas(hi, per);
      tpwm_pin_model_i.meas(hi, per);
      chk(32'(hi), 32'(16 * (2 << i)));
      chk(32'(per), 32'(37 * (2 << i)));
    end
    rdc(`TPWM_OFF_STATUS, 32'hC8, 32'h80);
    chk({31'h0, irq}, 32'h0);
    wr(`TPWM_OFF_CTRL1, 8'hC1);
    repeat (2) @(posedge mclk);
    chk({30'h0, wake, irq}, 32'h3);
    wr(`TPWM_OFF_CMP2_LO, 8'h30);
    tpwm_pin_model_i.meas(hi, per);
    tpwm_pin_model_i.meas(hi, per);
    chk(32'(hi), 32'd256);
    chk(32'(per), 32'd424);
    chk({31'h0, pin2}, 32'h1);
    // ==============================
    // External clock with no pin stops the count
    wr(`TPWM_OFF_CTRL2, 8'hBC);
    apb(1'b0, `TPWM_OFF_CNT, 8'h00, 4'h0);
    cnt_v = rd_v;
    repeat (20) @(posedge mclk);
    rdc(`TPWM_OFF_CNT, 32'hFFFF, cnt_v & 32'hFFFF);
    test_done();
  end
endmodule
